//--- design/dvm_pkg.sv
// Constants, register map and gain table of the DAC volume, mute and mono block.
package dvm_pkg;
   // ****************************************
   // Bus and data widths.
   // ****************************************
   localparam int ADR_W = 10;
   localparam int SMP_W = 16;
   localparam int GAIN_FRAC = 15;
   // ****************************************
   // Register indices; byte address is four times the index.
   // ****************************************
   localparam logic [7:0] IDX_VOL_LEFT  = 8'h1e;
   localparam logic [7:0] IDX_VOL_RIGHT = 8'h1f;
   localparam logic [7:0] IDX_DIG_ONE   = 8'h21;
   localparam logic [7:0] IDX_CONV      = 8'h40;
   localparam logic [7:0] IDX_STATUS    = 8'h41;
   // ****************************************
   // Field positions.
   // ****************************************
   localparam int BIT_VOL_UPDATE = 8;
   localparam int BIT_MUTE       = 3;
   localparam int BIT_MUTE_MODE  = 9;
   localparam int BIT_MUTE_RATE  = 10;
   localparam int BIT_MONO       = 12;
   localparam int BIT_DEEMPHASIS_SELECT_LO  = 1;
   localparam int BIT_RAMP_BUSY  = 16;
   // ****************************************
   // Codes and ramp dividers.
   // ****************************************
   localparam logic [7:0] VOL_UNITY = 8'hc0;
   localparam logic [7:0] VOL_MUTE  = 8'h00;
   localparam logic [4:0] RAMP_FAST_LAST = 5'h01;
   localparam logic [4:0] RAMP_SLOW_LAST = 5'h1f;
   // Gain of attenuation steps 0..15 in Q1.15; each 16 steps halve the gain.
   localparam logic [15:0] GAIN_TABLE [16] = '{
      16'h7fff, 16'h7a98, 16'h7569, 16'h7073, 16'h6bb3, 16'h6725, 16'h62ca, 16'h5e9d,
      16'h5a9e, 16'h56c9, 16'h531f, 16'h4f9b, 16'h4c3f, 16'h4905, 16'h45f0, 16'h42fb};
endpackage : dvm_pkg

//--- design/dvm_gain_rom.sv
// Volume code to gain lookup with a registered read port.
`timescale 1ns/10ps
`default_nettype none
module dvm_gain_rom (
   // Clock and reset.
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Lookup.
   input  wire logic [7:0]  code_i,
   output var  logic [15:0] mant_o,
   output var  logic [3:0]  shift_o
);
   import dvm_pkg::*;
   logic [7:0] att;

   // Codes at or above unity all give 0 dB, so attenuation saturates at zero.
   always_comb begin
      att = (code_i >= VOL_UNITY) ? 8'h00 : 8'(VOL_UNITY - code_i);
   end

   // Fraction of a 6 dB octave from the table, whole octaves as a shift.
   always_ff @(posedge clk_i) begin
      if (rst_i || code_i == VOL_MUTE) begin
         mant_o  <= 16'h0000;
         shift_o <= 4'h0;
      end else begin
         mant_o  <= GAIN_TABLE[att[3:0]];
         shift_o <= att[7:4];
      end
   end

   chk_unity_gain: assert property (@(posedge clk_i) disable iff (rst_i)
      code_i >= VOL_UNITY |=> mant_o == GAIN_TABLE[0] && shift_o == 4'h0)
      else $error("Code at or above unity did not give full gain.");
   chk_code_mute: assert property (@(posedge clk_i) disable iff (rst_i)
      code_i == VOL_MUTE |=> mant_o == 16'h0000)
      else $error("Mute code did not give zero gain.");
endmodule : dvm_gain_rom
`default_nettype wire

//--- design/dvm_scale.sv
// Multiplies one sample by a gain mantissa and octave shift, registered out.
`timescale 1ns/10ps
`default_nettype none
module dvm_scale (
   // Clock and reset.
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   // Sample and gain.
   input  wire logic [dvm_pkg::SMP_W-1:0] smp_i,
   input  wire logic [15:0]              mant_i,
   input  wire logic [3:0]               shift_i,
   output var  logic [dvm_pkg::SMP_W-1:0] smp_o
);
   import dvm_pkg::*;
   logic signed [32:0] prod;
   logic signed [32:0] scaled;

   // Arithmetic shift keeps the sign; small negative samples decay to minus one, small positive ones to zero.
   always_comb begin
      prod   = $signed(smp_i) * $signed({1'b0, mant_i});
      scaled = prod >>> (GAIN_FRAC + int'(shift_i));
   end

   // The product is registered so the output never glitches.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         smp_o <= '0;
      end else begin
         smp_o <= scaled[SMP_W-1:0];
      end
   end
endmodule : dvm_scale
`default_nettype wire

//--- design/dvm_top.sv
// Playback volume, soft mute, mono mix and de-emphasis select with Wishbone registers.
//
// The Wishbone register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module dvm_top (
   // Clock and reset.
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   // Wishbone classic slave.
   input  wire logic                      wb_cyc_i,
   input  wire logic                      wb_stb_i,
   input  wire logic                      wb_we_i,
   input  wire logic [dvm_pkg::ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]                wb_sel_i,
   input  wire logic [31:0]               wb_dat_i,
   output var  logic [31:0]               wb_dat_o,
   output var  logic                      wb_ack_o,
   // Upstream samples.
   input  wire logic                      smp_valid_i,
   input  wire logic [dvm_pkg::SMP_W-1:0] smp_left_i,
   input  wire logic [dvm_pkg::SMP_W-1:0] smp_right_i,
   // Processed samples and filter select.
   output var  logic                      out_valid_o,
   output var  logic [dvm_pkg::SMP_W-1:0] out_left_o,
   output var  logic [dvm_pkg::SMP_W-1:0] out_right_o,
   output var  logic [1:0]                deemphasis_select_o
);
   import dvm_pkg::*;

   // ****************************************
   // Declarations.
   // ****************************************
   logic [7:0]       idx;
   logic             req;
   logic             wr;
   logic [31:0]      rd_nxt;
   logic             mute_r;
   logic             mute_d_r;
   logic             unmute_ramp_select_r;
   logic             mute_ramp_rate_r;
   logic             mono_r;
   logic [1:0]       deemphasis_select_r;
   logic [1:0]       conv_on_r;
   logic [7:0]       pend_r [2];
   logic [7:0]       target_r [2];
   logic [7:0]       applied_r [2];
   logic [7:0]       goal [2];
   logic [1:0]       ramp_up_r;
   logic             upd_r;
   logic [4:0]       div_cnt_r;
   logic             tick;
   logic             mono_act;
   logic [SMP_W:0]   mix_sum;
   logic [SMP_W-1:0] mix;
   logic [SMP_W-1:0] smp_in [2];
   logic [SMP_W-1:0] s0_r [2];
   logic [SMP_W-1:0] s1 [2];
   logic [15:0]      mant [2];
   logic [3:0]       shift [2];
   logic             v1_r;
   logic             v2_r;

   // ****************************************
   // Wishbone slave.
   // ****************************************
   // Each access is answered one cycle after it is seen; unmapped ones read zero.
   always_comb begin
      idx = wb_adr_i[ADR_W-1:2];
      req = wb_cyc_i && wb_stb_i && !wb_ack_o;
      wr  = req && wb_we_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   // Read mux; the update strobe is write-only and reads as zero.
   always_comb begin
      rd_nxt = 32'h0000_0000;
      unique case (idx)
         IDX_VOL_LEFT:  rd_nxt[7:0] = pend_r[0];
         IDX_VOL_RIGHT: rd_nxt[7:0] = pend_r[1];
         IDX_DIG_ONE: begin
            rd_nxt[BIT_MONO]      = mono_r;
            rd_nxt[BIT_MUTE_RATE] = mute_ramp_rate_r;
            rd_nxt[BIT_MUTE_MODE] = unmute_ramp_select_r;
            rd_nxt[BIT_MUTE]      = mute_r;
            rd_nxt[BIT_DEEMPHASIS_SELECT_LO+:2] = deemphasis_select_r;
         end
         IDX_CONV:   rd_nxt[1:0] = conv_on_r;
         IDX_STATUS: begin
            rd_nxt[7:0]           = applied_r[0];
            rd_nxt[15:8]          = applied_r[1];
            rd_nxt[BIT_RAMP_BUSY] = |ramp_up_r || (mute_r && |{applied_r[0], applied_r[1]});
         end
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (req && !wb_we_i) begin
         wb_dat_o <= rd_nxt;
      end
   end

   // ****************************************
   // Control register writes.
   // ****************************************
   // Digital control one and converter enables; mute starts clear.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mute_r               <= 1'b0;
         unmute_ramp_select_r <= 1'b0;
         mute_ramp_rate_r     <= 1'b0;
         mono_r               <= 1'b0;
         deemphasis_select_r             <= 2'b00;
         conv_on_r            <= 2'b11;
      end else if (wr) begin
         if (idx == IDX_DIG_ONE && wb_sel_i[0]) begin
            mute_r   <= wb_dat_i[BIT_MUTE];
            deemphasis_select_r <= wb_dat_i[BIT_DEEMPHASIS_SELECT_LO+:2];
         end
         if (idx == IDX_DIG_ONE && wb_sel_i[1]) begin
            unmute_ramp_select_r <= wb_dat_i[BIT_MUTE_MODE];
            mute_ramp_rate_r     <= wb_dat_i[BIT_MUTE_RATE];
            mono_r               <= wb_dat_i[BIT_MONO];
         end
         if (idx == IDX_CONV && wb_sel_i[0]) begin
            conv_on_r <= wb_dat_i[1:0];
         end
      end
   end

   assign deemphasis_select_o = deemphasis_select_r;

   // Pending codes; the strobe is held one cycle so both pending codes are settled.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_r[0] <= VOL_UNITY;
         pend_r[1] <= VOL_UNITY;
         upd_r     <= 1'b0;
      end else begin
         upd_r <= wr && (idx == IDX_VOL_LEFT || idx == IDX_VOL_RIGHT)
                  && wb_sel_i[1] && wb_dat_i[BIT_VOL_UPDATE];
         if (wr && idx == IDX_VOL_LEFT && wb_sel_i[0]) begin
            pend_r[0] <= wb_dat_i[7:0];
         end
         if (wr && idx == IDX_VOL_RIGHT && wb_sel_i[0]) begin
            pend_r[1] <= wb_dat_i[7:0];
         end
      end
   end

   // Both channels take their new code on the same edge.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         target_r[0] <= VOL_UNITY;
         target_r[1] <= VOL_UNITY;
      end else if (upd_r) begin
         target_r[0] <= pend_r[0];
         target_r[1] <= pend_r[1];
      end
   end

   // ****************************************
   // Ramp timing.
   // ****************************************
   // One tick every 2 or every 32 samples; a change to fast mid-count ticks on the next sample instead of wrapping.
   always_comb begin
      tick = smp_valid_i
             && (div_cnt_r >= (mute_ramp_rate_r ? RAMP_SLOW_LAST : RAMP_FAST_LAST));
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_cnt_r <= 5'h00;
      end else if (tick) begin
         div_cnt_r <= 5'h00;
      end else if (smp_valid_i) begin
         div_cnt_r <= 5'(div_cnt_r + 5'h01);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mute_d_r <= 1'b0;
      end else begin
         mute_d_r <= mute_r;
      end
   end

   // ****************************************
   // Per-channel gain ramp and scaling.
   // ****************************************
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_ch
         // Ramps walk every code, above unity too, so a full-range ramp spans 255 steps.
         // Those top steps change no level, but skipping them would shorten the ramp time.
         always_comb begin
            goal[ch] = mute_r ? VOL_MUTE : target_r[ch];
         end

         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               applied_r[ch] <= VOL_UNITY;
               ramp_up_r[ch] <= 1'b0;
            end else if (mute_r) begin
               ramp_up_r[ch] <= 1'b0;
               if (tick && applied_r[ch] != VOL_MUTE) begin
                  applied_r[ch] <= 8'(applied_r[ch] - 8'h01);
               end
            end else if (mute_d_r && unmute_ramp_select_r) begin
               ramp_up_r[ch] <= 1'b1;
            end else if (ramp_up_r[ch] && applied_r[ch] < goal[ch]) begin
               if (tick) begin
                  applied_r[ch] <= 8'(applied_r[ch] + 8'h01);
               end
            end else begin
               ramp_up_r[ch] <= 1'b0;
               applied_r[ch] <= goal[ch];
            end
         end

         // Disabled converters are silent; mono goes only to the enabled one.
         always_comb begin
            smp_in[ch] = ch == 0 ? smp_left_i : smp_right_i;
         end

         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               s0_r[ch] <= '0;
            end else if (smp_valid_i) begin
               if (!conv_on_r[ch]) begin
                  s0_r[ch] <= '0;
               end else if (mono_act) begin
                  s0_r[ch] <= mix;
               end else begin
                  s0_r[ch] <= smp_in[ch];
               end
            end
         end

         dvm_gain_rom u_rom (
            .clk_i   (clk_i),
            .rst_i   (rst_i),
            .code_i  (applied_r[ch]),
            .mant_o  (mant[ch]),
            .shift_o (shift[ch])
         );

         dvm_scale u_scale (
            .clk_i   (clk_i),
            .rst_i   (rst_i),
            .smp_i   (s0_r[ch]),
            .mant_i  (mant[ch]),
            .shift_i (shift[ch]),
            .smp_o   (s1[ch])
         );
      end
   endgenerate

   // ****************************************
   // Mono mix and output.
   // ****************************************
   // Halving the sum is the 6 dB drop that keeps the mix from clipping.
   always_comb begin
      mono_act = mono_r && !(conv_on_r[0] && conv_on_r[1]);
      mix_sum  = {smp_left_i[SMP_W-1], smp_left_i} + {smp_right_i[SMP_W-1], smp_right_i};
      mix      = mix_sum[SMP_W:1];
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         v1_r <= 1'b0;
         v2_r <= 1'b0;
      end else begin
         v1_r <= smp_valid_i;
         v2_r <= v1_r;
      end
   end

   assign out_valid_o = v2_r;
   assign out_left_o  = s1[0];
   assign out_right_o = s1[1];

   // ****************************************
   // Assertions.
   // ****************************************
   chk_mute_step_down: assert property (@(posedge clk_i) disable iff (rst_i)
      mute_r && tick && applied_r[0] != VOL_MUTE |=> applied_r[0] == $past(applied_r[0]) - 8'h01)
      else $error("Soft mute did not lower the gain by one step.");
   chk_reset_unmuted: assert property (@(posedge clk_i)
      rst_i |=> !mute_r && applied_r[0] == VOL_UNITY)
      else $error("Mute request not clear after reset.");
   chk_jump_unmute: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(mute_r) && !unmute_ramp_select_r |=> applied_r[1] == $past(goal[1]))
      else $error("Immediate un-mute did not restore the volume.");
   chk_ramp_step_up: assert property (@(posedge clk_i) disable iff (rst_i)
      !mute_r && ramp_up_r[0] && tick && applied_r[0] < goal[0]
      |=> applied_r[0] == $past(applied_r[0]) + 8'h01)
      else $error("Ramped un-mute did not rise by one step.");
   chk_fast_rate: assert property (@(posedge clk_i) disable iff (rst_i)
      smp_valid_i && !mute_ramp_rate_r && div_cnt_r == RAMP_FAST_LAST |-> tick)
      else $error("Fast ramp tick off its interval.");
   chk_slow_rate: assert property (@(posedge clk_i) disable iff (rst_i)
      smp_valid_i && mute_ramp_rate_r && div_cnt_r < RAMP_SLOW_LAST |-> !tick)
      else $error("Slow ramp ticked early.");
   chk_mono_mix: assert property (@(posedge clk_i) disable iff (rst_i)
      smp_valid_i && mono_act && conv_on_r[0] |=> s0_r[0] == $past(mix))
      else $error("Mono mix not sent to the enabled channel.");
   chk_mono_silent: assert property (@(posedge clk_i) disable iff (rst_i)
      smp_valid_i && !conv_on_r[1] |=> s0_r[1] == '0)
      else $error("Disabled channel produced output.");
   chk_stereo_wins: assert property (@(posedge clk_i) disable iff (rst_i)
      smp_valid_i && conv_on_r == 2'b11 |=> s0_r[1] == $past(smp_right_i))
      else $error("Stereo not kept with both channels enabled.");
   chk_vol_together: assert property (@(posedge clk_i) disable iff (rst_i)
      upd_r |=> target_r[0] == $past(pend_r[0]) && target_r[1] == $past(pend_r[1]))
      else $error("Volume update did not apply both codes.");

   cov_mute_done: cover property (@(posedge clk_i) disable iff (rst_i)
      mute_r && applied_r[0] == VOL_MUTE);
   cov_ramp_unmute: cover property (@(posedge clk_i) disable iff (rst_i)
      $fell(ramp_up_r[0]) && !mute_r);
   cov_mono_out: cover property (@(posedge clk_i) disable iff (rst_i)
      smp_valid_i && mono_act);
   cov_vol_update: cover property (@(posedge clk_i) disable iff (rst_i) upd_r);
endmodule : dvm_top
`default_nettype wire

//--- dv/dvm_src_model.sv
// Upstream sample source that hands paired left/right frames to the block.
`timescale 1ns/10ps
`default_nettype none
module dvm_src_model (
   // Clock and reset.
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Burst request from the bench.
   input  wire logic        req_i,
   input  wire logic [15:0] num_i,
   input  wire logic [3:0]  gap_i,
   input  wire logic [15:0] left_i,
   input  wire logic [15:0] right_i,
   output var  logic        busy_o,
   // Frames toward the block.
   output var  logic        valid_o,
   output var  logic [15:0] left_o,
   output var  logic [15:0] right_o
);
   logic [15:0] cnt_r;
   logic [3:0]  wait_r;

   assign busy_o = (cnt_r != 16'h0000);

   // One frame per gap; between frames the data toggles so stale data is never trusted.
   always_ff @(posedge clk_i) begin
      valid_o <= 1'b0;
      left_o  <= ~left_o;
      right_o <= ~right_o;
      if (rst_i) begin
         cnt_r   <= 16'h0000;
         wait_r  <= 4'h0;
         left_o  <= 16'h0000;
         right_o <= 16'h0000;
      end else if (req_i) begin
         cnt_r  <= num_i;
         wait_r <= 4'h0;
      end else if (busy_o && wait_r == 4'h0) begin
         valid_o <= 1'b1;
         left_o  <= left_i;
         right_o <= right_i;
         cnt_r   <= cnt_r - 16'h0001;
         wait_r  <= gap_i;
      end else if (busy_o) begin
         wait_r <= wait_r - 4'h1;
      end
   end
endmodule : dvm_src_model
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the volume, soft mute, mono mix and de-emphasis block.
`timescale 1ns/10ps
`default_nettype none
module tb;
   import dvm_pkg::*;
   logic        clk_i, rst_i, cyc, stb, we, ack, smp_valid, out_valid, req, busy;
   logic [9:0]  adr;
   logic [3:0]  sel, gap;
   logic [31:0] wdat, rdat, rd;
   logic [15:0] num, l_in, r_in, smp_l, smp_r, out_l, out_r, lfsr_r, m;
   logic [1:0]  deemphasis_select;
   logic [7:0]  codes [8] = '{8'h00, 8'h30, 8'hbf, 8'hc0, 8'he5, 8'hff, 8'h01, 8'h90};
   int          mismatches, num_checks, frames_sent, outs_seen;

   dvm_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .smp_valid_i(smp_valid), .smp_left_i(smp_l), .smp_right_i(smp_r),
      .out_valid_o(out_valid), .out_left_o(out_l), .out_right_o(out_r),
      .deemphasis_select_o(deemphasis_select));

   dvm_src_model u_src (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .num_i(num),
      .gap_i(gap), .left_i(l_in), .right_i(r_in), .busy_o(busy), .valid_o(smp_valid),
      .left_o(smp_l), .right_o(smp_r));

   // ****************************************
   // Reference model and bus tasks.
   // ****************************************
   function automatic logic [15:0] gain(input logic [15:0] s, input logic [7:0] c);
      int     d;
      int     sh;
      longint g;
      longint p;
      d = 192 - int'(c);
      g = (c >= 8'hc0) ? 64'sd32767 : longint'(GAIN_TABLE[d % 16]);
      sh = (c >= 8'hc0) ? 0 : d / 16;
      p = (longint'($signed(s)) * g) >>> (15 + sh);
      return (c == 8'h00) ? 16'h0000 : p[15:0];
   endfunction : gain

   function automatic logic [15:0] mix(input logic [15:0] a, input logic [15:0] b);
      longint t;
      t = (longint'($signed(a)) + longint'($signed(b))) >>> 1;
      return t[15:0];
   endfunction : mix

   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Holds the request until ack is sampled; the gap cycle keeps accesses apart.
   task automatic wb_xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      sel <= 4'hf;
      wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) mismatches++;
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask : wb_xfer

   task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
      wb_xfer(1'b0, idx, 32'h0000_0000);
      check(rd, exp);
   endtask : rdchk

   task automatic stchk(input logic [15:0] exp);
      wb_xfer(1'b0, IDX_STATUS, 32'h0000_0000);
      check({16'h0000, rd[15:0]}, {16'h0000, exp});
   endtask : stchk

   // Long bursts run back to back, short ones with idle cycles between frames.
   task automatic frames(input int n);
      int k;
      k = 0;
      num <= 16'(n);
      gap <= (n > 100) ? 4'h0 : 4'h3;
      req <= 1'b1;
      @(posedge clk_i);
      req <= 1'b0;
      do begin
         @(posedge clk_i);
         k++;
      end while (busy !== 1'b0 && k < 70000);
      if (k >= 70000) mismatches++;
      repeat (3) @(posedge clk_i);
      frames_sent += n;
   endtask : frames

   task automatic stereo(input logic [7:0] cl, input logic [7:0] cr);
      lfsr_r = lfsr(lfsr_r);
      l_in <= lfsr_r;
      lfsr_r = lfsr(lfsr_r);
      r_in <= lfsr_r;
      frames(1);
      check(out_l, gain(l_in, cl));
      check(out_r, gain(r_in, cr));
   endtask : stereo

   task automatic setvol(input logic [7:0] cl, input logic [7:0] cr);
      wb_xfer(1'b1, IDX_VOL_LEFT, {24'h0000_00, cl});
      wb_xfer(1'b1, IDX_VOL_RIGHT, {24'h0000_01, cr});
      repeat (3) @(posedge clk_i);
   endtask : setvol

   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : summarize

   // Clock, output counter and watchdog.
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   always @(posedge clk_i) if (out_valid === 1'b1) outs_seen++;

   initial begin
      repeat (50000) @(posedge clk_i);
      mismatches++;
      summarize();
   end

   // ****************************************
   // Scenarios.
   // ****************************************
   initial begin
      {rst_i, cyc, stb, we, req, adr, sel, gap, wdat, num, l_in, r_in} = '0;
      rst_i = 1'b1;
      lfsr_r = 16'h0034;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rdchk(IDX_DIG_ONE, 32'h0000_0000);
      rdchk(IDX_VOL_LEFT, 32'h0000_00c0);
      rdchk(IDX_VOL_RIGHT, 32'h0000_00c0);
      rdchk(IDX_CONV, 32'h0000_0003);
      rdchk(8'h7f, 32'h0000_0000);
      check({30'h0, deemphasis_select}, 32'h0000_0000);
      stereo(8'hc0, 8'hc0);
      // A pending left code must wait for the update strobe.
      wb_xfer(1'b1, IDX_VOL_LEFT, 32'h0000_0030);
      stereo(8'hc0, 8'hc0);
      for (int i = 0; i < 8; i++) begin
         setvol(codes[i], codes[7 - i]);
         stereo(codes[i], codes[7 - i]);
      end
      for (int i = 0; i < 4; i++) begin
         wb_xfer(1'b1, IDX_DIG_ONE, 32'(i) << 1);
         check({30'h0, deemphasis_select}, 32'(i));
      end
      setvol(8'h90, 8'ha8);
      for (int i = 1; i < 4; i++) begin
         wb_xfer(1'b1, IDX_CONV, 32'(i));
         wb_xfer(1'b1, IDX_DIG_ONE, 32'h0000_1000);
         lfsr_r = lfsr(lfsr_r);
         l_in <= lfsr_r;
         r_in <= ~lfsr_r + 16'h1234;
         frames(1);
         m = mix(l_in, r_in);
         check(out_l, i == 3 ? gain(l_in, 8'h90) : i == 1 ? gain(m, 8'h90) : 0);
         check(out_r, i == 3 ? gain(r_in, 8'ha8) : i == 2 ? gain(m, 8'ha8) : 0);
      end
      wb_xfer(1'b1, IDX_DIG_ONE, 32'h0000_0000);
      // Fast soft mute from a low code: six frames hold exactly three ticks.
      setvol(8'h04, 8'h04);
      wb_xfer(1'b1, IDX_DIG_ONE, 32'h0000_0008);
      frames(6);
      stchk(16'h0101);
      frames(2);
      stchk(16'h0000);
      stereo(8'h00, 8'h00);
      // Immediate un-mute, as suits the start of a new track.
      wb_xfer(1'b1, IDX_DIG_ONE, 32'h0000_0000);
      stchk(16'h0404);
      wb_xfer(1'b1, IDX_DIG_ONE, 32'h0000_0008);
      frames(8);
      stchk(16'h0000);
      // Ramped un-mute, as suits resuming within a track.
      wb_xfer(1'b1, IDX_DIG_ONE, 32'h0000_0200);
      frames(4);
      stchk(16'h0202);
      frames(6);
      stchk(16'h0404);
      // Full-range slow mute from FFh, then full-range fast ramped un-mute: 255 steps each.
      setvol(8'hff, 8'hff);
      wb_xfer(1'b1, IDX_DIG_ONE, 32'h0000_0408);
      frames(8128);
      rdchk(IDX_STATUS, 32'h0001_0101);
      frames(32);
      stchk(16'h0000);
      wb_xfer(1'b1, IDX_DIG_ONE, 32'h0000_0200);
      frames(508);
      rdchk(IDX_STATUS, 32'h0001_fefe);
      frames(2);
      stchk(16'hffff);
      // Every control field reads back; unused bits of the register read zero.
      wb_xfer(1'b1, IDX_DIG_ONE, 32'h0000_17ff);
      rdchk(IDX_DIG_ONE, 32'h0000_160e);
      check(32'(outs_seen), 32'(frames_sent));
      summarize();
   end
endmodule : tb
`default_nettype wire
